// >>> logic/sev_status_regs.sv
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Clear-status zeroes the event flags and all four device event registers.
// - Over the serial link, clear-status keeps the pending response untouched.
// - Over the instrument bus, clear-status keeps response and message-available flag.
// - Enable-mask write carries 0 to 255 and loads the 8-bit mask.
// - A fractional enable-mask argument is rounded to an integer before loading.
// - The enable mask is zero after power-on.
// - Enable-mask query returns the stored mask, leaving it unchanged.
// - Event query returns the flags, then clears them.
// - Operation-complete flag sets once all commands before the marker finish.
module sev_status_regs
  import sev_pkg::*;
#(
  parameter int unsigned FRAC_W = 4
) (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                clear_status,
  input  wire logic                mask_write,
  input  wire logic [8+FRAC_W-1:0] mask_write_value,
  input  wire logic                mask_query,
  input  wire logic                event_query,
  input  wire logic                opc_mark,
  input  wire logic                cmd_busy,
  input  wire logic                ev_command_error,
  input  wire logic                ev_execution_error,
  input  wire logic                ev_device_error,
  input  wire logic                ev_query_error,
  input  wire logic [7:0]          dev_event_set_a,
  input  wire logic [7:0]          dev_event_set_b,
  input  wire logic [7:0]          dev_event_set_c,
  input  wire logic [7:0]          dev_event_set_d,
  input  wire logic                response_taken,
  output logic [7:0]               event_enable_mask,
  output logic [7:0]               standard_event_flags,
  output logic [7:0]               device_event_reg_a,
  output logic [7:0]               device_event_reg_b,
  output logic [7:0]               device_event_reg_c,
  output logic [7:0]               device_event_reg_d,
  output logic                     event_summary,
  output logic [7:0]               response_data,
  output logic                     message_available_flag
);

  if (FRAC_W < 1 || FRAC_W > 16) begin : g_check_frac
    $error("sev_status_regs: FRAC_W must lie in 1 to 16");
  end

  localparam int unsigned VAL_W = 8 + FRAC_W;
  localparam logic [VAL_W:0] HALF_LSB = (VAL_W+1)'(1) << (FRAC_W - 1);

  logic [7:0]           enable_mask_q;
  logic [7:0]           enable_mask_d;
  logic [7:0]           response_data_q;
  logic [7:0]           response_data_d;
  logic                 msg_avail_q;
  logic                 msg_avail_d;
  sev_opc_state_t       opc_state_q;
  sev_opc_state_t       opc_state_d;
  logic                 opc_set;
  logic [VAL_W:0]       rounded_sum;
  logic [8:0]           rounded_int;
  logic                 mask_in_range;
  logic [7:0]           event_set;
  logic [7:0]           flags_value;
  logic [7:0]           dev_set   [DEV_REG_COUNT];
  logic [7:0]           dev_value [DEV_REG_COUNT];
  sev_resp_t            resp_kind;

  // Round half up: add half an LSB of the integer part, then truncate
  always_comb begin
    rounded_sum   = {1'b0, mask_write_value} + HALF_LSB;
    rounded_int   = rounded_sum[VAL_W:FRAC_W];
    mask_in_range = (rounded_int <= {1'b0, MASK_MAX_VALUE});
  end

  // Enable mask
  always_comb begin
    enable_mask_d = enable_mask_q;
    if (mask_write && mask_in_range) begin
      enable_mask_d = rounded_int[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      enable_mask_q <= ENABLE_MASK_RESET;
    end else begin
      enable_mask_q <= enable_mask_d;
    end
  end

  // Completion marker: done at once when idle, else when processing ends
  always_comb begin
    opc_state_d = opc_state_q;
    opc_set     = 1'b0;
    unique case (opc_state_q)
      SEV_OPC_IDLE: begin
        if (opc_mark && !cmd_busy) begin
          opc_set = 1'b1;
        end else if (opc_mark) begin
          opc_state_d = SEV_OPC_ARMED;
        end
      end
      SEV_OPC_ARMED: begin
        if (!cmd_busy) begin
          opc_set     = 1'b1;
          opc_state_d = SEV_OPC_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      opc_state_q <= SEV_OPC_IDLE;
    end else begin
      opc_state_q <= opc_state_d;
    end
  end

  // Event sources in the shared layout; an out-of-range mask is an execution error
  always_comb begin
    event_set                    = '0;
    event_set[EV_CMD_ERR_BIT]    = ev_command_error;
    event_set[EV_EXEC_ERR_BIT]   = ev_execution_error | (mask_write && !mask_in_range);
    event_set[EV_DEV_ERR_BIT]    = ev_device_error;
    event_set[EV_QUERY_ERR_BIT]  = ev_query_error;
    event_set[EV_OP_DONE_BIT]    = opc_set;
  end

  sev_sticky_reg #(
    .WIDTH     (REG_W),
    .RESET_VAL (EVENT_FLAGS_RESET),
    .SET_MASK  (EV_USED_MASK)
  ) u_event_flags (
    .clk      (clk),
    .rst_n    (rst_n),
    .set_bits (event_set),
    .clear    (clear_status || event_query),
    .value_q  (flags_value)
  );

  assign dev_set[0] = dev_event_set_a;
  assign dev_set[1] = dev_event_set_b;
  assign dev_set[2] = dev_event_set_c;
  assign dev_set[3] = dev_event_set_d;

  for (genvar i = 0; i < DEV_REG_COUNT; i++) begin : g_dev_regs
    sev_sticky_reg #(
      .WIDTH     (REG_W),
      .RESET_VAL (DEV_EVENT_RESET),
      .SET_MASK  (8'hff)
    ) u_dev_reg (
      .clk      (clk),
      .rst_n    (rst_n),
      .set_bits (dev_set[i]),
      .clear    (clear_status),
      .value_q  (dev_value[i])
    );
  end

  // Query answers; the event query has priority over the mask query
  always_comb begin
    if (event_query) begin
      resp_kind = SEV_RESP_EVENT;
    end else if (mask_query) begin
      resp_kind = SEV_RESP_ENABLE;
    end else begin
      resp_kind = SEV_RESP_NONE;
    end
  end

  always_comb begin
    response_data_d = response_data_q;
    unique case (resp_kind)
      SEV_RESP_EVENT:  response_data_d = flags_value;
      SEV_RESP_ENABLE: response_data_d = enable_mask_q;
      SEV_RESP_NONE:   response_data_d = response_data_q;
      default:         response_data_d = response_data_q;
    endcase
  end

  // Pending answer: clear-status never touches it on either link
  always_comb begin
    msg_avail_d = msg_avail_q;
    if (resp_kind != SEV_RESP_NONE) begin
      msg_avail_d = 1'b1;
    end else if (response_taken) begin
      msg_avail_d = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      response_data_q <= 8'h00;
      msg_avail_q     <= 1'b0;
    end else begin
      response_data_q <= response_data_d;
      msg_avail_q     <= msg_avail_d;
    end
  end

  assign event_enable_mask      = enable_mask_q;
  assign standard_event_flags   = flags_value;
  assign device_event_reg_a     = dev_value[0];
  assign device_event_reg_b     = dev_value[1];
  assign device_event_reg_c     = dev_value[2];
  assign device_event_reg_d     = dev_value[3];
  assign event_summary          = |(flags_value & enable_mask_q);
  assign response_data          = response_data_q;
  assign message_available_flag = msg_avail_q;

endmodule

`default_nettype wire

// >>> logic/sev_pkg.sv
package sev_pkg;

  // Shared bit layout of the event flags and the enable mask
  localparam int unsigned EV_POWER_ON_BIT    = 7;
  localparam int unsigned EV_USER_REQ_BIT    = 6;
  localparam int unsigned EV_CMD_ERR_BIT     = 5;
  localparam int unsigned EV_EXEC_ERR_BIT    = 4;
  localparam int unsigned EV_DEV_ERR_BIT     = 3;
  localparam int unsigned EV_QUERY_ERR_BIT   = 2;
  localparam int unsigned EV_REQ_CTRL_BIT    = 1;
  localparam int unsigned EV_OP_DONE_BIT     = 0;

  // Bit position of the message-available flag in the status byte
  localparam int unsigned MSG_AVAIL_BIT      = 4;

  localparam int unsigned REG_W              = 8;
  localparam int unsigned DEV_REG_COUNT      = 4;

  // Bits this unit may ever set in the standard event flags
  localparam logic [7:0]  EV_USED_MASK       = 8'hbd;

  localparam logic [7:0]  ENABLE_MASK_RESET  = 8'h00;
  localparam logic [7:0]  EVENT_FLAGS_RESET  = 8'h80;
  localparam logic [7:0]  DEV_EVENT_RESET    = 8'h00;
  localparam logic [7:0]  MASK_MAX_VALUE     = 8'hff;

  // Answer kinds held in the response register
  typedef enum logic [1:0] {
    SEV_RESP_NONE   = 2'b00,
    SEV_RESP_ENABLE = 2'b01,
    SEV_RESP_EVENT  = 2'b10
  } sev_resp_t;

  // Completion-marker tracking
  typedef enum logic [0:0] {
    SEV_OPC_IDLE  = 1'b0,
    SEV_OPC_ARMED = 1'b1
  } sev_opc_state_t;

endpackage

// >>> logic/sev_sticky_reg.sv
`timescale 1ns/1ps
`default_nettype none

// Latching event register: bits set by pulses, cleared as a whole.
// A set that arrives with the clear survives it.
module sev_sticky_reg
  import sev_pkg::*;
#(
  parameter int unsigned       WIDTH     = REG_W,
  parameter logic [WIDTH-1:0]  RESET_VAL = '0,
  parameter logic [WIDTH-1:0]  SET_MASK  = '1
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] set_bits,
  input  wire logic             clear,
  output logic      [WIDTH-1:0] value_q
);

  logic [WIDTH-1:0] value_d;

  always_comb begin
    value_d = (clear ? '0 : value_q) | (set_bits & SET_MASK);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      value_q <= RESET_VAL;
    end else begin
      value_q <= value_d;
    end
  end

endmodule

`default_nettype wire

// >>> verification/sev_status_regs_chk.sv
`timescale 1ns/1ps
`default_nettype none

module sev_status_regs_chk
  import sev_pkg::*;
#(
  parameter int unsigned FRAC_W = 4
) (
  input wire logic                clk,
  input wire logic                rst_n,
  input wire logic                clear_status,
  input wire logic                mask_write,
  input wire logic [8+FRAC_W-1:0] mask_write_value,
  input wire logic                mask_query,
  input wire logic                event_query,
  input wire logic                opc_mark,
  input wire logic                cmd_busy,
  input wire logic                ev_command_error,
  input wire logic [7:0]          dev_event_set_a,
  input wire logic                response_taken,
  input wire logic [7:0]          event_enable_mask,
  input wire logic [7:0]          standard_event_flags,
  input wire logic [7:0]          device_event_reg_a,
  input wire logic [7:0]          response_data,
  input wire logic                message_available_flag
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Half-up rounded mask value, top bit flags overflow past 255
  logic [8+FRAC_W:0] rnd;
  assign rnd = {1'b0, mask_write_value} + {1'b1, {(FRAC_W-1){1'b0}}};

  AST_CLS_DEV: assert property (clear_status |=> device_event_reg_a == $past(dev_event_set_a))
    else $error("device event register not cleared");
  AST_FLAGS_CLR: assert property ((clear_status || event_query) |=> !standard_event_flags[7])
    else $error("power-on flag survived a clear");
  AST_CLS_KEEP: assert property (clear_status && !mask_query && !event_query && !response_taken
    |=> $stable(response_data) && $stable(message_available_flag)) else $error("clear disturbed pending answer");
  AST_MASK_LOAD: assert property (mask_write && !rnd[8+FRAC_W]
    |=> event_enable_mask == $past(rnd[8+FRAC_W-1:FRAC_W])) else $error("mask not loaded rounded");
  AST_MASK_REFUSE: assert property (mask_write && rnd[8+FRAC_W]
    |=> $stable(event_enable_mask) && standard_event_flags[4]) else $error("oversized mask accepted");
  AST_MASK_HOLD: assert property (!mask_write |=> $stable(event_enable_mask))
    else $error("mask changed without a write");
  AST_MASK_ANS: assert property (mask_query && !event_query && !mask_write
    |=> response_data == $past(event_enable_mask) && message_available_flag) else $error("bad mask answer");
  AST_EV_ANS: assert property (event_query |=> response_data == $past(standard_event_flags) && message_available_flag)
    else $error("bad event answer");
  AST_OPC_SET: assert property (opc_mark && !cmd_busy |=> standard_event_flags[0])
    else $error("operation complete not set");
  AST_CME_BIT: assert property (ev_command_error |=> standard_event_flags[5])
    else $error("command error not at bit 5");
  AST_UNUSED: assert property (!standard_event_flags[6] && !standard_event_flags[1])
    else $error("unused event bit set");

  cover property (clear_status && message_available_flag);
  cover property (mask_write && rnd[8+FRAC_W]);
  cover property (opc_mark && cmd_busy ##[1:8] !cmd_busy);
endmodule

bind sev_status_regs sev_status_regs_chk #(.FRAC_W(FRAC_W)) u_chk (.*);

`default_nettype wire

// >>> verification/sev_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// Remote controller: sends one-cycle command strobes, collects answers
module sev_host_model
  import sev_pkg::*;
#(
  parameter int unsigned FRAC_W = 4
) (
  input  wire logic                clk,
  input  wire logic [7:0]          response_data,
  input  wire logic                message_available_flag,
  output logic                     clear_status,
  output logic                     mask_write,
  output logic [8+FRAC_W-1:0]      mask_write_value,
  output logic                     mask_query,
  output logic                     event_query,
  output logic                     opc_mark,
  output logic                     response_taken
);
  logic [4:0] s = '0;
  assign {opc_mark, event_query, mask_query, mask_write, clear_status} = s;
  initial mask_write_value = '0;
  initial response_taken = 1'b0;

  // k: 0 clear, 1 mask write, 2 mask query, 3 event query, 4 completion mark
  task automatic send(input int k, input int gap, input logic [8+FRAC_W-1:0] v);
    repeat (gap) @(posedge clk);
    @(posedge clk);
    s <= 5'h01 << k;
    mask_write_value <= v;
    @(posedge clk);
    s <= '0;
    mask_write_value <= ~v;
  endtask

  task automatic take(output logic [7:0] r, output logic m);
    #1;
    r = response_data;
    m = message_available_flag;
    @(posedge clk);
    response_taken <= 1'b1;
    @(posedge clk);
    response_taken <= 1'b0;
  endtask
endmodule

`default_nettype wire

// >>> verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench
  import sev_pkg::*;
;
  logic clk = 1'b0, rst_n = 1'b0, cmd_busy = 1'b0;
  logic ev_command_error = 1'b0, ev_execution_error = 1'b0, ev_device_error = 1'b0, ev_query_error = 1'b0;
  logic [7:0] dev_event_set_a = '0, dev_event_set_b = '0, dev_event_set_c = '0, dev_event_set_d = '0;
  logic clear_status, mask_write, mask_query, event_query, opc_mark, response_taken;
  logic event_summary, message_available_flag, m;
  logic [11:0] mask_write_value;
  logic [7:0] event_enable_mask, standard_event_flags, response_data, d;
  logic [7:0] device_event_reg_a, device_event_reg_b, device_event_reg_c, device_event_reg_d;
  int miscompares = 0, comparisons = 0;
  logic [11:0] wv [6] = '{12'h240, 12'h248, 12'h247, 12'h000, 12'hff0, 12'hff8};
  logic [7:0]  we [6] = '{8'h24, 8'h25, 8'h24, 8'h00, 8'hff, 8'hff};

  sev_status_regs dut (.*);
  sev_host_model host (.*);

  always #50 clk = ~clk;

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    comparisons++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic ask(input int k, input int gap, output logic [7:0] r);
    host.send(k, gap, '0);
    host.take(r, m);
    #1 chk("answer_pending", 8'h01, {7'h00, m});
    chk("answer_released", 8'h00, {7'h00, message_available_flag});
  endtask

  task automatic stop_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    #100000;
    miscompares++;
    stop_test();
  end

  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    ask(2, 0, d); chk("mask_after_reset", 8'h00, d);
    chk("summary_reset", 8'h00, {7'h00, event_summary});
    foreach (wv[i]) begin
      host.send(1, i, wv[i]);
      ask(2, 0, d); chk("mask", we[i], d);
    end
    ask(3, 0, d); chk("events", 8'h90, d);
    ask(3, 2, d); chk("events_cleared", 8'h00, d);
    @(posedge clk);
    {ev_command_error, ev_execution_error, ev_device_error, ev_query_error} <= 4'hf;
    {dev_event_set_a, dev_event_set_b, dev_event_set_c, dev_event_set_d} <= {4{8'h5a}};
    @(posedge clk);
    {ev_command_error, ev_execution_error, ev_device_error, ev_query_error} <= 4'h0;
    {dev_event_set_a, dev_event_set_b, dev_event_set_c, dev_event_set_d} <= '0;
    #1 chk("dev_a_set", 8'h5a, device_event_reg_a);
    chk("dev_b_set", 8'h5a, device_event_reg_b);
    chk("dev_c_set", 8'h5a, device_event_reg_c);
    chk("dev_d_set", 8'h5a, device_event_reg_d);
    chk("summary_set", 8'h01, {7'h00, event_summary});
    ask(3, 0, d); chk("events", 8'h3c, d);
    @(posedge clk);
    cmd_busy <= 1'b1;
    host.send(4, 0, '0);
    repeat (3) @(posedge clk);
    #1 chk("opc_busy", 8'h00, standard_event_flags);
    @(posedge clk);
    cmd_busy <= 1'b0;
    ask(3, 1, d); chk("opc_armed", 8'h01, d);
    host.send(4, 1, '0);
    #1 chk("opc_done", 8'h01, standard_event_flags);
    host.send(2, 0, '0);
    host.send(0, 0, '0);
    #1 chk("flags_cls", 8'h00, standard_event_flags);
    chk("dev_a_cls", 8'h00, device_event_reg_a);
    chk("dev_b_cls", 8'h00, device_event_reg_b);
    chk("dev_c_cls", 8'h00, device_event_reg_c);
    chk("summary_cls", 8'h00, {7'h00, event_summary});
    chk("dev_d_cls", 8'h00, device_event_reg_d);
    chk("resp_cls", 8'hff, response_data);
    chk("mav_cls", 8'h01, {7'h00, message_available_flag});
    host.take(d, m);
    chk("resp_after_cls", 8'hff, d);
    chk("mav_after_cls", 8'h01, {7'h00, m});
    stop_test();
  end
endmodule

`default_nettype wire
